/* File: inc/gpds_pkg.sv */
// gpio port package: register map, field layout, bus carriers
package gpds_pkg;
  localparam int PIN_COUNT = 8;
  localparam int ADDR_WIDTH = 12;
  // register byte offsets
  localparam logic [11:0] OFFS_DATA_LAST = 12'h3FF;
  localparam logic [11:0] OFFS_DIR = 12'h400;
  localparam logic [11:0] OFFS_SENSE = 12'h404;
  localparam logic [11:0] OFFS_BOTH = 12'h408;
  localparam logic [11:0] OFFS_POL = 12'h40C;
  localparam logic [11:0] OFFS_MASK = 12'h410;
  localparam logic [11:0] OFFS_RAW = 12'h414;
  localparam logic [11:0] OFFS_MIS = 12'h418;
  localparam logic [11:0] OFFS_CLR = 12'h41C;
  // data alias mask sits in address bits [9:2]
  localparam int ALIAS_LSB = 2;
  localparam int ALIAS_MSB = 9;
  localparam logic [7:0] FIELD_RESET = 8'h00;
  localparam logic [31:0] RSVD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic sel;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } gpds_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpds_pins_t;
endpackage

/* File: logic/gpds_irq_detect.sv */
// per-pin interrupt detection: edge/level sense, polarity, raw status
`timescale 1ns/1ps
module gpds_irq_detect #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pinNow,
  input wire logic [WIDTH-1:0] pinPrev,
  input wire logic [WIDTH-1:0] senseBits,
  input wire logic [WIDTH-1:0] bothEdgeBits,
  input wire logic [WIDTH-1:0] polarityBits,
  input wire logic [WIDTH-1:0] clearPulse,
  output logic [WIDTH-1:0] rawStatus
);
  logic [WIDTH-1:0] raw_q;
  logic [WIDTH-1:0] raw_d;

  always_comb begin
    logic rise;
    logic fall;
    logic edgeHit;
    rise = 1'b0;
    fall = 1'b0;
    edgeHit = 1'b0;
    raw_d = raw_q;
    for (int i = 0; i < WIDTH; i++) begin
      rise = pinNow[i] & ~pinPrev[i];
      fall = ~pinNow[i] & pinPrev[i];
      if (bothEdgeBits[i]) begin
        edgeHit = rise | fall;
      end else begin
        edgeHit = polarityBits[i] ? rise : fall;
      end
      if (senseBits[i]) begin
        raw_d[i] = (pinNow[i] == polarityBits[i]);
      end else if (edgeHit) begin
        raw_d[i] = 1'b1;
      end else if (clearPulse[i]) begin
        raw_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      raw_q <= '0;
    end else begin
      raw_q <= raw_d;
    end
  end

  assign rawStatus = raw_q;
endmodule // gpds_irq_detect

/* File: logic/gpds_port.sv */
// eight-pin gpio port: aliased data, direction, interrupt sense and status
`timescale 1ns/1ps
module gpds_port #(
  parameter int WIDTH = gpds_pkg::PIN_COUNT
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire gpds_pkg::gpds_req_t busReq,
  output logic [31:0] busRdata,
  input wire logic [WIDTH-1:0] pinIn,
  output gpds_pkg::gpds_pins_t pinDrive,
  output logic irqOut
);
  logic [WIDTH-1:0] data_q;
  logic [WIDTH-1:0] data_d;
  logic [WIDTH-1:0] dir_q;
  logic [WIDTH-1:0] dir_d;
  logic [WIDTH-1:0] sense_q;
  logic [WIDTH-1:0] sense_d;
  logic [WIDTH-1:0] both_q;
  logic [WIDTH-1:0] both_d;
  logic [WIDTH-1:0] pol_q;
  logic [WIDTH-1:0] pol_d;
  logic [WIDTH-1:0] mask_q;
  logic [WIDTH-1:0] mask_d;
  logic [WIDTH-1:0] syncA_q;
  logic [WIDTH-1:0] syncB_q;
  logic [WIDTH-1:0] prev_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [WIDTH-1:0] clrPulse;
  logic [WIDTH-1:0] rawStatus;
  logic [WIDTH-1:0] maskedStatus;
  logic [WIDTH-1:0] aliasMask;
  logic [WIDTH-1:0] outBits;
  logic [WIDTH-1:0] inBits;
  logic [WIDTH-1:0] current;
  logic [WIDTH-1:0] wrField;
  logic [WIDTH-1:0] wrEnable;
  logic isData;
  logic wr;
  logic rd;
  logic wrDir;
  logic wrSense;
  logic wrBoth;
  logic wrPol;
  logic wrMask;
  logic wrClr;

  function automatic logic [31:0] zext(input logic [WIDTH-1:0] v);
    zext = gpds_pkg::RSVD_ZERO;
    zext[WIDTH-1:0] = v;
  endfunction

  // exact hit on one control register offset
  function automatic logic regHit(input logic [11:0] a, input logic [11:0] offs);
    regHit = (a == offs);
  endfunction

  // every offset below the control block is a data alias
  assign isData = busReq.addr <= gpds_pkg::OFFS_DATA_LAST;
  assign aliasMask = busReq.addr[gpds_pkg::ALIAS_MSB:gpds_pkg::ALIAS_LSB];
  assign wr = busReq.sel & busReq.write;
  assign rd = busReq.sel & ~busReq.write;
  assign wrField = busReq.wdata[WIDTH-1:0];
  assign outBits = data_q & dir_q;
  assign inBits = syncB_q & ~dir_q;
  assign current = outBits | inBits;
  assign wrEnable = aliasMask & dir_q;
  assign maskedStatus = rawStatus & mask_q;

  // write strobes, one per writable control register
  assign wrDir = wr & regHit(busReq.addr, gpds_pkg::OFFS_DIR);
  assign wrSense = wr & regHit(busReq.addr, gpds_pkg::OFFS_SENSE);
  assign wrBoth = wr & regHit(busReq.addr, gpds_pkg::OFFS_BOTH);
  assign wrPol = wr & regHit(busReq.addr, gpds_pkg::OFFS_POL);
  assign wrMask = wr & regHit(busReq.addr, gpds_pkg::OFFS_MASK);
  assign wrClr = wr & regHit(busReq.addr, gpds_pkg::OFFS_CLR);

  // data latch: input pins and alias-masked bits keep their value
  always_comb begin
    data_d = data_q;
    if (wr && isData) begin
      data_d = (data_q & ~wrEnable) |
               (wrField & wrEnable);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      data_q <= gpds_pkg::FIELD_RESET;
    end else begin
      data_q <= data_d;
    end
  end

  // direction and interrupt configuration; clear is a one-cycle pulse
  always_comb begin
    dir_d = dir_q;
    sense_d = sense_q;
    both_d = both_q;
    pol_d = pol_q;
    mask_d = mask_q;
    clrPulse = '0;
    if (wrDir) begin
      dir_d = wrField;
    end
    if (wrSense) begin
      sense_d = wrField;
    end
    if (wrBoth) begin
      both_d = wrField;
    end
    if (wrPol) begin
      pol_d = wrField;
    end
    if (wrMask) begin
      mask_d = wrField;
    end
    if (wrClr) begin
      clrPulse = wrField;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dir_q <= gpds_pkg::FIELD_RESET;
      sense_q <= gpds_pkg::FIELD_RESET;
      both_q <= gpds_pkg::FIELD_RESET;
      pol_q <= gpds_pkg::FIELD_RESET;
      mask_q <= gpds_pkg::FIELD_RESET;
    end else begin
      dir_q <= dir_d;
      sense_q <= sense_d;
      both_q <= both_d;
      pol_q <= pol_d;
      mask_q <= mask_d;
    end
  end

  // per-pin sampling: two stages into the clock domain, one history stage
  for (genvar p = 0; p < WIDTH; p++) begin : g_pinSample
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        syncA_q[p] <= 1'b0;
        syncB_q[p] <= 1'b0;
        prev_q[p] <= 1'b0;
      end else begin
        syncA_q[p] <= pinIn[p];
        syncB_q[p] <= syncA_q[p];
        prev_q[p] <= syncB_q[p];
      end
    end
  end

  // read data, registered one cycle after the select; write-only offsets read zero
  always_comb begin
    rdata_d = gpds_pkg::RSVD_ZERO;
    if (rd) begin
      if (isData) begin
        rdata_d = zext(current & aliasMask);
      end else begin
        unique case (busReq.addr)
          gpds_pkg::OFFS_DIR: rdata_d = zext(dir_q);
          gpds_pkg::OFFS_SENSE: rdata_d = zext(sense_q);
          gpds_pkg::OFFS_BOTH: rdata_d = zext(both_q);
          gpds_pkg::OFFS_POL: rdata_d = zext(pol_q);
          gpds_pkg::OFFS_MASK: rdata_d = zext(mask_q);
          gpds_pkg::OFFS_RAW: rdata_d = zext(rawStatus);
          gpds_pkg::OFFS_MIS: rdata_d = zext(maskedStatus);
          default: rdata_d = gpds_pkg::RSVD_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= gpds_pkg::RSVD_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // detection compares the second sync stage with its one-cycle history
  gpds_irq_detect #(.WIDTH(WIDTH)) u_detect (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pinNow(syncB_q),
    .pinPrev(prev_q),
    .senseBits(sense_q),
    .bothEdgeBits(both_q),
    .polarityBits(pol_q),
    .clearPulse(clrPulse),
    .rawStatus(rawStatus)
  );

  assign busRdata = rdata_q;
  // pins drive straight from the data latch; direction gates the driver
  assign pinDrive.out = data_q;
  assign pinDrive.oe = dir_q;
  // combined interrupt: raw status gated by the per-pin mask
  assign irqOut = |maskedStatus;
endmodule // gpds_port

/* File: test/gpds_pin_model.sv */
// external pin model: output pins loop back, input pins follow the bench level
`timescale 1ns/1ps
module gpds_pin_model (
  input wire gpds_pkg::gpds_pins_t pinDrive,
  input wire logic [7:0] extLevel,
  output logic [7:0] pinIn
);
  assign pinIn = (pinDrive.oe & pinDrive.out) | (~pinDrive.oe & extLevel);
endmodule // gpds_pin_model

/* File: test/gpds_port_checker.sv */
// assertions on the gpio port register bus and pins
`timescale 1ns/1ps
module gpds_port_checker #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire gpds_pkg::gpds_req_t busReq,
  input wire logic [31:0] busRdata,
  input wire logic [WIDTH-1:0] pinIn,
  input wire gpds_pkg::gpds_pins_t pinDrive,
  input wire logic irqOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic wr, rd, dat;
  logic [7:0] en, nOut, nOe;
  assign wr = busReq.sel && busReq.write;
  assign rd = busReq.sel && !busReq.write;
  assign dat = busReq.addr < 12'h400;
  assign en = busReq.addr[9:2] & pinDrive.oe;
  assign nOut = (wr && dat) ? (pinDrive.out & ~en) | (busReq.wdata[7:0] & en) : pinDrive.out;
  assign nOe = (wr && busReq.addr == 12'h400) ? busReq.wdata[7:0] : pinDrive.oe;
  property p_rsvd; busRdata[31:8] == 24'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_rst; $fell(sys_rst) |-> pinDrive == '0 && !irqOut && busRdata == '0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_dir; 1'b1 |=> pinDrive.oe == $past(nOe); endproperty
  a_dir: assert property (p_dir) else $error("bad direction");
  property p_data; 1'b1 |=> pinDrive.out == $past(nOut); endproperty
  a_data: assert property (p_data) else $error("bad data write");
  property p_rd; rd && dat |=> (busRdata[7:0] & $past(en)) == $past(pinDrive.out & en); endproperty
  a_rd: assert property (p_rd) else $error("bad data read");
  property p_rddir; rd && busReq.addr == 12'h400 |=> busRdata[7:0] == $past(pinDrive.oe); endproperty
  a_rddir: assert property (p_rddir) else $error("bad direction read");
  property p_unmap; rd && busReq.addr > 12'h41C |=> busRdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_idle; !rd |=> busRdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_mskoff; wr && busReq.addr == 12'h410 && busReq.wdata[7:0] == 8'h00 |=> !irqOut; endproperty
  a_mskoff: assert property (p_mskoff) else $error("interrupt with all pins masked");
endmodule // gpds_port_checker
bind gpds_port gpds_port_checker #(.WIDTH(WIDTH)) gpds_port_checker_inst (.mclk(mclk),
  .sys_rst(sys_rst), .busReq(busReq), .busRdata(busRdata), .pinIn(pinIn),
  .pinDrive(pinDrive), .irqOut(irqOut));

/* File: test/gpds_port_tb.sv */
// self-checking testbench for the gpio port
`timescale 1ns/1ps
module gpds_port_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  gpds_pkg::gpds_req_t busReq = '0;
  logic [31:0] busRdata;
  logic [7:0] pinIn;
  logic [7:0] extLevel = 8'h00;
  gpds_pkg::gpds_pins_t pinDrive;
  logic irqOut;
  int nFail = 0;
  int samplesChecked = 0;
  always #5 mclk = ~mclk;
  gpds_port gpds_port_inst (.mclk(mclk), .sys_rst(sys_rst), .busReq(busReq),
    .busRdata(busRdata), .pinIn(pinIn), .pinDrive(pinDrive), .irqOut(irqOut));
  gpds_pin_model gpds_pin_model_inst (.pinDrive(pinDrive), .extLevel(extLevel), .pinIn(pinIn));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e) begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk);
    busReq <= '{1'b1, w, a, d};
    @(negedge mclk);
    busReq.sel <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk("busRdata", e, busRdata);
  endtask
  // input change needs the two sync stages plus the raw status flop
  task automatic pin(input logic [7:0] l, input logic e);
    extLevel = l;
    repeat (4) @(negedge mclk);
    chk("irqOut", {31'h0, e}, {31'h0, irqOut});
  endtask
  task automatic giveVerdict();
    $display("checked %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200us;
    nFail++;
    giveVerdict();
  end
  initial begin
    repeat (3) @(negedge mclk);
    sys_rst <= 1'b0;
    rd(12'h400, 32'h0);
    rd(12'h404, 32'h0);
    rd(12'h408, 32'h0);
    acc(1'b1, 12'h404, 32'hFFFF_FFA5);
    rd(12'h404, 32'h0000_00A5);
    acc(1'b1, 12'h404, 32'h0);
    acc(1'b1, 12'h400, 32'h0000_000F);
    chk("oe", 32'h0F, {24'h0, pinDrive.oe});
    acc(1'b1, 12'h3FC, 32'hFF);
    acc(1'b1, 12'h004, 32'h00);
    chk("out", 32'h0E, {24'h0, pinDrive.out});
    extLevel = 8'hA0;
    repeat (3) @(negedge mclk);
    rd(12'h3FC, 32'hAE);
    rd(12'h0C0, 32'h20);
    rd(12'h500, 32'h0);
    $display("data tests done");
    acc(1'b1, 12'h408, 32'h10);
    acc(1'b1, 12'h41C, 32'hFF);
    acc(1'b1, 12'h410, 32'h10);
    pin(8'hB0, 1'b1);
    rd(12'h414, 32'h10);
    acc(1'b1, 12'h41C, 32'h10);
    chk("irqOut", 32'h0, {31'h0, irqOut});
    pin(8'hA0, 1'b1);
    acc(1'b1, 12'h408, 32'h0);
    acc(1'b1, 12'h41C, 32'hFF);
    pin(8'hB0, 1'b0);
    pin(8'hA0, 1'b1);
    acc(1'b1, 12'h404, 32'h10);
    acc(1'b1, 12'h40C, 32'h10);
    acc(1'b1, 12'h41C, 32'hFF);
    pin(8'hA0, 1'b0);
    pin(8'hB0, 1'b1);
    pin(8'hA0, 1'b0);
    pin(8'hB0, 1'b1);
    acc(1'b1, 12'h410, 32'h0);
    chk("irqOut", 32'h0, {31'h0, irqOut});
    $display("interrupt tests done");
    giveVerdict();
  end
endmodule // gpds_port_tb
